// ==== core/tmr_pkg.sv ====
// Purpose: shared constants and carrier types for the dual timer/counter block
// Assumes: 32-bit classic Wishbone register bus, one 40 MHz clock
// Notes:   register offsets are byte addresses of aligned 32-bit words
package tmr_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CLK_HZ             = 40_000_000;
	localparam int unsigned MACHINE_CYCLE_CLKS = 6;       // cpu clocks per machine cycle
	localparam int unsigned DIV_W              = 3;       // divider width, holds up to 8

	// ****************************************************************
	// register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] MODE_REG_ADR   = 8'h00;
	localparam logic [7:0] RUN_REG_ADR    = 8'h04;
	localparam logic [7:0] LOW0_REG_ADR   = 8'h08;
	localparam logic [7:0] HIGH0_REG_ADR  = 8'h0C;
	localparam logic [7:0] LOW1_REG_ADR   = 8'h10;
	localparam logic [7:0] HIGH1_REG_ADR  = 8'h14;
	localparam logic [7:0] TOGGLE_REG_ADR = 8'h18;
	localparam logic [7:0] STATUS_REG_ADR = 8'h1C;
	localparam logic [7:0] MASK_REG_ADR   = 8'h20;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int MODE_SEL_LSB0 = 0;    // mode_select_low/high of counter 0
	localparam int CT_SEL_BIT0   = 2;    // timer_counter_select of counter 0
	localparam int GATE_EN_BIT0  = 3;    // external_gate_enable of counter 0
	localparam int MODE_SEL_LSB1 = 4;
	localparam int CT_SEL_BIT1   = 6;
	localparam int GATE_EN_BIT1  = 7;
	localparam int RUN_BIT0      = 4;    // run_control 0 in run_flag_register
	localparam int OVF_BIT0      = 5;
	localparam int RUN_BIT1      = 6;
	localparam int OVF_BIT1      = 7;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0] MODE_RST  = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [1:0] BITS_RST  = 2'h0;

	// operating modes, encodings 00..11
	localparam logic [1:0] MODE_13BIT  = 2'h0;
	localparam logic [1:0] MODE_16BIT  = 2'h1;
	localparam logic [1:0] MODE_RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT  = 2'h3;

	// result of one count step of a counter
	typedef struct packed {
		logic       ovf;
		logic [7:0] lo;
		logic [7:0] hi;
	} cnt_res_t;

	// wishbone request carrier
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

endpackage : tmr_pkg

// ==== core/dual_timer_counter.sv ====
// Purpose: two up-counters with four modes, gating, overflow flags, toggle outputs
// Assumes: classic Wishbone slave on clk_i, synchronous active-high reset
// Notes:   pins and gate inputs are synchronised by two flip-flops before use
`timescale 1ns/1ps

module dual_timer_counter
	import tmr_pkg::*;
#(
	parameter int unsigned MC_CLKS = tmr_pkg::MACHINE_CYCLE_CLKS
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [1:0]  int_vector_ack_i,
	input  wire logic [1:0]  external_gate_input_i,
	input  wire logic        count_input_pin_zero_i,
	output logic             count_input_pin_zero_o,
	output logic             count_input_pin_zero_oe_n_o,
	input  wire logic        count_input_pin_one_i,
	output logic             count_input_pin_one_o,
	output logic             count_input_pin_one_oe_n_o,
	output logic             irq_o
);
	import tmr_pkg::*;

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	if (MC_CLKS < 2 || MC_CLKS > (1 << DIV_W))
		$error("MC_CLKS must lie between 2 and the divider range");

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic [7:0]       mode;
		logic [1:0]       run;
		logic [1:0]       ovf;
		logic [1:0][7:0]  lo;
		logic [1:0][7:0]  hi;
		logic [1:0]       tog_en;
		logic [1:0]       tog_out;
		logic [1:0]       status;
		logic [1:0]       mask;
		logic [1:0]       pin_s1;
		logic [1:0]       pin_s2;
		logic [1:0]       sample;
		logic [1:0]       gate_s1;
		logic [1:0]       gate_s2;
		logic             ack;
		logic [31:0]      dat;
		logic             irq;
	} state_t;

	state_t state_reg;
	state_t state_next;

	// one count step of a counter in modes 0 to 2; mode 3 is handled by the caller
	function automatic cnt_res_t count_step(
		input logic [1:0] m,
		input logic [7:0] lo,
		input logic [7:0] hi,
		input logic       inc
	);
		cnt_res_t r;
		logic [12:0] v13;
		logic [15:0] v16;
		r   = '{ovf: 1'b0, lo: lo, hi: hi};
		v13 = {hi, lo[4:0]} + 13'h0001;
		v16 = {hi, lo} + 16'h0001;
		if (inc) begin
			case (m)
				MODE_13BIT: begin
					// thirteen bit count, upper low-byte bits left alone
					r.hi = v13[12:5];
					r.lo = {lo[7:5], v13[4:0]};
					r.ovf = ({hi, lo[4:0]} == 13'h1FFF);
				end
				MODE_16BIT: begin
					r.hi  = v16[15:8];
					r.lo  = v16[7:0];
					r.ovf = ({hi, lo} == 16'hFFFF);
				end
				MODE_RELOAD: begin
					// reload low byte from high byte
					r.ovf = (lo == 8'hFF);
					r.lo  = r.ovf ? hi : lo + 8'h01;
				end
				default: begin
					r.ovf = 1'b0;
				end
			endcase
		end
		return r;
	endfunction : count_step

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	wb_req_t    req;
	logic       tick;
	logic       access;
	logic       wr;
	logic       rd;
	logic [1:0] edge_seen;
	logic [1:0] run_ok;
	logic [1:0] inc;
	logic [1:0] ovf_evt;
	logic [1:0] flag_set;
	logic [1:0] mode_c0;
	logic [1:0] mode_c1;
	logic [1:0] ovf_base;
	logic [1:0] stat_base;
	logic [1:0] tog_new;
	logic [1:0] tog_hit;
	cnt_res_t   res0;
	cnt_res_t   res1;
	logic [8:0] split_hi;

	// bus inputs travel together
	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

	always_comb begin
		state_next = state_reg;
		mode_c0    = state_reg.mode[MODE_SEL_LSB0 +: 2];
		mode_c1    = state_reg.mode[MODE_SEL_LSB1 +: 2];
		tick             = (state_reg.div == DIV_W'(MC_CLKS - 1));
		state_next.div   = tick ? '0 : state_reg.div + DIV_W'(1);

		// two-flop synchronisers; only the second stage is read by logic
		state_next.pin_s1  = {count_input_pin_one_i, count_input_pin_zero_i};
		state_next.pin_s2  = state_reg.pin_s1;
		state_next.gate_s1 = external_gate_input_i;
		state_next.gate_s2 = state_reg.gate_s1;

		// sample once per machine cycle, edge is previous high then low
		// two samples, two machine cycles, per recognised edge
		edge_seen = tick ? (state_reg.sample & ~state_reg.pin_s2) : 2'b00;
		if (tick) begin
			state_next.sample = state_reg.pin_s2;
		end

		// run gating with optional external gate
		// separate gate enable bit per counter
		run_ok[0] = state_reg.run[0] & (~state_reg.mode[GATE_EN_BIT0] | state_reg.gate_s2[0]);
		run_ok[1] = (mode_c0 == MODE_SPLIT ? 1'b1 : state_reg.run[1])
		            & (~state_reg.mode[GATE_EN_BIT1] | state_reg.gate_s2[1]);

		// edge counted at the detecting tick, visible in the next machine cycle
		inc[0] = tick & run_ok[0] & (state_reg.mode[CT_SEL_BIT0] ? edge_seen[0] : 1'b1);
		// counter 1 in mode 3 is stopped
		inc[1] = tick & run_ok[1] & (mode_c1 != MODE_SPLIT)
		         & (state_reg.mode[CT_SEL_BIT1] ? edge_seen[1] : 1'b1);

		// counting resumes from held value, run writes touch no count
		res0 = count_step(mode_c0, state_reg.lo[0], state_reg.hi[0], inc[0]);
		res1 = count_step(mode_c1, state_reg.lo[1], state_reg.hi[1], inc[1]);
		split_hi = {1'b0, state_reg.hi[0]} + 9'h001;
		ovf_evt  = {res1.ovf, res0.ovf};
		flag_set = 2'b00;

		// counter 0 mode 3: two 8-bit counters, high byte borrows run 1 and flag 1
		if (mode_c0 == MODE_SPLIT) begin
			res0.lo  = inc[0] ? state_reg.lo[0] + 8'h01 : state_reg.lo[0];
			res0.hi  = (tick & state_reg.run[1]) ? split_hi[7:0] : state_reg.hi[0];
			flag_set = {tick & state_reg.run[1] & split_hi[8], inc[0] & (state_reg.lo[0] == 8'hFF)};
			ovf_evt  = {res1.ovf, flag_set[0]};
		end else begin
			flag_set = ovf_evt;
		end
		state_next.lo[0] = res0.lo;
		state_next.hi[0] = res0.hi;
		state_next.lo[1] = res1.lo;
		state_next.hi[1] = res1.hi;

		// wishbone: one wait state, registered ack and data
		access           = req.cyc & req.stb & ~state_reg.ack;
		wr               = access & req.we & req.sel[0];
		rd               = access & ~req.we;
		state_next.ack   = access;
		state_next.dat   = state_reg.dat;
		ovf_base         = state_reg.ovf;
		stat_base        = state_reg.status;
		tog_new          = 2'b00;
		if (rd) begin
			state_next.dat = 32'h0000_0000;
			case (req.adr & 8'hFC)
				MODE_REG_ADR:   state_next.dat[7:0] = state_reg.mode;
				RUN_REG_ADR: begin
					state_next.dat[RUN_BIT0] = state_reg.run[0];
					state_next.dat[OVF_BIT0] = state_reg.ovf[0];
					state_next.dat[RUN_BIT1] = state_reg.run[1];
					state_next.dat[OVF_BIT1] = state_reg.ovf[1];
				end
				LOW0_REG_ADR:   state_next.dat[7:0] = state_reg.lo[0];
				HIGH0_REG_ADR:  state_next.dat[7:0] = state_reg.hi[0];
				LOW1_REG_ADR:   state_next.dat[7:0] = state_reg.lo[1];
				HIGH1_REG_ADR:  state_next.dat[7:0] = state_reg.hi[1];
				TOGGLE_REG_ADR: state_next.dat[1:0] = state_reg.tog_en;
				STATUS_REG_ADR: begin
					state_next.dat[1:0] = state_reg.status;
					stat_base           = 2'b00;    // read clears the sticky bits
				end
				MASK_REG_ADR:   state_next.dat[1:0] = state_reg.mask;
				default:        state_next.dat = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			case (req.adr & 8'hFC)
				MODE_REG_ADR: state_next.mode = req.dat[7:0];
				RUN_REG_ADR: begin
					state_next.run = {req.dat[RUN_BIT1], req.dat[RUN_BIT0]};
					ovf_base       = {req.dat[OVF_BIT1], req.dat[OVF_BIT0]};
				end
				// count byte writes win over increments
				LOW0_REG_ADR:   state_next.lo[0] = req.dat[7:0];
				HIGH0_REG_ADR:  state_next.hi[0] = req.dat[7:0];
				LOW1_REG_ADR:   state_next.lo[1] = req.dat[7:0];
				HIGH1_REG_ADR:  state_next.hi[1] = req.dat[7:0];
				TOGGLE_REG_ADR: begin
					tog_new           = req.dat[1:0] & ~state_reg.tog_en;
					state_next.tog_en = req.dat[1:0];
				end
				MASK_REG_ADR:   state_next.mask = req.dat[1:0];
				default:        state_next.mode = state_reg.mode;
			endcase
		end

		// vector acknowledge or software clears; a hardware set wins
		state_next.ovf    = (ovf_base & ~int_vector_ack_i) | flag_set;
		state_next.status = stat_base | flag_set;
		state_next.irq    = |(state_next.status & state_next.mask);

		// toggle the count pin on each overflow except a mode 3 high-byte overflow
		// freshly enabled toggle output starts at one
		tog_hit            = ovf_evt & state_reg.tog_en;
		state_next.tog_out = (state_reg.tog_out ^ tog_hit) | tog_new;
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	// synchronous reset to constants only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg         <= '0;
			state_reg.mode    <= MODE_RST;
			state_reg.lo      <= {COUNT_RST, COUNT_RST};
			state_reg.hi      <= {COUNT_RST, COUNT_RST};
			state_reg.tog_en  <= BITS_RST;
			state_reg.tog_out <= 2'b11;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state register
	assign wb_dat_o                    = state_reg.dat;
	assign wb_ack_o                    = state_reg.ack;
	assign irq_o                       = state_reg.irq;
	assign count_input_pin_zero_o      = state_reg.tog_out[0];
	assign count_input_pin_zero_oe_n_o = ~state_reg.tog_en[0];   // low while driving
	assign count_input_pin_one_o       = state_reg.tog_out[1];
	assign count_input_pin_one_oe_n_o  = ~state_reg.tog_en[1];

endmodule : dual_timer_counter

// ==== dv/pulse_source.sv ====
// Purpose: far-side pulse source for a count input pin
// Assumes: runs on the bench clock
// Notes:   idles high, as a pulled-up pin would
`timescale 1ns/1ps
module pulse_source #(
	parameter int HOLD = 6
) (
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic [3:0] n_i,
	output logic            pin_o,
	output logic            busy_o
);
	int cnt  = 0;
	int left = 0;
	initial pin_o = 1'b1;
	initial busy_o = 1'b0;
	// level hold time
	// every level lasts HOLD clocks, so no level slips between samples
	always @(posedge clk_i) begin
		if (!busy_o && go_i) begin
			busy_o <= 1'b1;
			left   <= 2 * n_i;
			cnt    <= HOLD;
		end else if (busy_o) begin
			if (cnt > 1)
				cnt <= cnt - 1;
			else if (left == 0)
				busy_o <= 1'b0;
			else begin
				pin_o <= ~pin_o;
				left  <= left - 1;
				cnt   <= HOLD;
			end
		end
	end
endmodule : pulse_source

// ==== dv/dual_timer_counter_asserts.sv ====
// Purpose: port-level timing checks of dual_timer_counter
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into the design, sees its ports only
`timescale 1ns/1ps
module dual_timer_counter_asserts (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        count_input_pin_zero_o,
	input wire logic        count_input_pin_zero_oe_n_o,
	input wire logic        count_input_pin_one_o,
	input wire logic        count_input_pin_one_oe_n_o,
	input wire logic        irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ****
	// bus answer
	// ****
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	rd_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	dat_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i) else $error("read data moved");
	// ****
	// pins and reset
	// ****
	oe_write_a: assert property ($changed(count_input_pin_zero_oe_n_o) || $changed(count_input_pin_one_oe_n_o)
		|-> wb_ack_o && wb_we_i) else $error("pin enable moved without write");
	toggle_init0_a: assert property ($fell(count_input_pin_zero_oe_n_o) |-> count_input_pin_zero_o)
		else $error("pin zero not high on enable");
	toggle_init1_a: assert property ($fell(count_input_pin_one_oe_n_o) |-> count_input_pin_one_o)
		else $error("pin one not high on enable");
	rst_out_a: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && count_input_pin_zero_o
		&& count_input_pin_one_o && count_input_pin_zero_oe_n_o && count_input_pin_one_oe_n_o)
		else $error("outputs wrong after reset");
endmodule : dual_timer_counter_asserts
bind dual_timer_counter dual_timer_counter_asserts u_dual_timer_counter_asserts (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .count_input_pin_zero_o, .count_input_pin_zero_oe_n_o,
	.count_input_pin_one_o, .count_input_pin_one_oe_n_o, .irq_o);

// ==== dv/dual_timer_counter_tb.sv ====
// Purpose: register-level tests of dual_timer_counter
// Assumes: package map, six-clock machine cycle
// Notes:   run windows span whole machine cycles, so counts are exact
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	samples_checked++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("mismatch %s exp %h got %h", nm, e, g); \
	end
module dual_timer_counter_tb;
	import tmr_pkg::*;
	logic        clk_i   = 1'b0;
	logic        rst_i   = 1'b1;
	wb_req_t     req     = '0;
	logic [1:0]  vec_ack = 2'h0;
	logic [1:0]  gate    = 2'h0;
	logic        go      = 1'b0;
	logic [3:0]  n_edges = 4'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, src_pin, busy, p0_o, p0_oe_n, p1_o, p1_oe_n, irq_o;
	logic [7:0]  d;
	int          n_fail          = 0;
	int          samples_checked = 0;
	always #12.5 clk_i = ~clk_i;
	dual_timer_counter u_dual_timer_counter (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc),
		.wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel),
		.wb_dat_i(req.dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .int_vector_ack_i(vec_ack),
		.external_gate_input_i(gate), .count_input_pin_zero_i(p0_oe_n ? src_pin : p0_o),
		.count_input_pin_zero_o(p0_o), .count_input_pin_zero_oe_n_o(p0_oe_n),
		.count_input_pin_one_i(p1_oe_n ? 1'b1 : p1_o), .count_input_pin_one_o(p1_o),
		.count_input_pin_one_oe_n_o(p1_oe_n), .irq_o(irq_o));
	pulse_source #(.HOLD(MACHINE_CYCLE_CLKS)) u_pulse_source (.clk_i(clk_i), .go_i(go),
		.n_i(n_edges), .pin_o(src_pin), .busy_o(busy));
	// one classic cycle; spans four edges, takes effect one edge after start
	task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] v, output logic [7:0] r);
		int t;
		t = 0;
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, we, a, 4'hf, {24'h00_0000, v}};
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 20);
		if (t == 20)
			n_fail++;
		r = wb_dat_o[7:0];
		req <= '0;
		@(posedge clk_i);
	endtask : bus
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e, input string nm);
		logic [7:0] r;
		bus(1'b0, a, 8'h00, r);
		`CHK(nm, e, r)
	endtask : chk_reg
	task automatic pulses(input logic [3:0] n);
		@(posedge clk_i);
		n_edges <= n;
		go      <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		do @(posedge clk_i); while (busy);
		repeat (20) @(posedge clk_i);
	endtask : pulses
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	// watchdog: the tests need well under 3000 cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		// ****
		// reset values, unmapped place
		// ****
		chk_reg(MODE_REG_ADR, MODE_RST, "mode");
		chk_reg(RUN_REG_ADR, 8'h00, "run");
		bus(1'b1, 8'h24, 8'hff, d);
		chk_reg(8'h24, 8'h00, "unmapped");
		// ****
		// timer: 13-bit wrap on counter 0, 16-bit low-to-high carry without wrap on counter 1, 40 ticks
		// ****
		bus(1'b1, MODE_REG_ADR, 8'h10, d);
		bus(1'b1, LOW0_REG_ADR, 8'h1e, d);
		bus(1'b1, HIGH0_REG_ADR, 8'hff, d);
		bus(1'b1, LOW1_REG_ADR, 8'hfe, d);
		bus(1'b1, RUN_REG_ADR, 8'h50, d);
		repeat (20) @(posedge clk_i);
		chk_reg(RUN_REG_ADR, 8'h70, "ovf0 set");
		repeat (212) @(posedge clk_i);
		// stop both but keep ovf0 set, so only the vector acknowledge below can clear it
		bus(1'b1, RUN_REG_ADR, 8'h20, d);
		chk_reg(LOW0_REG_ADR, 8'h06, "low0");
		chk_reg(HIGH0_REG_ADR, 8'h01, "high0");
		chk_reg(LOW1_REG_ADR, 8'h26, "low1");
		chk_reg(HIGH1_REG_ADR, 8'h01, "high1");
		`CHK("irq masked", 1'b0, irq_o)
		bus(1'b1, MASK_REG_ADR, 8'hff, d);
		`CHK("irq", 1'b1, irq_o)
		bus(1'b0, STATUS_REG_ADR, 8'h00, d);
		`CHK("irq cleared", 1'b0, irq_o)
		`CHK("status", 8'h01, d)
		@(posedge clk_i);
		vec_ack <= 2'h1;
		@(posedge clk_i);
		vec_ack <= 2'h0;
		chk_reg(RUN_REG_ADR, 8'h00, "ovf0 cleared");
		// ****
		// mode 2 reload with toggle on counter 1, 10 ticks
		// ****
		bus(1'b1, MODE_REG_ADR, 8'h20, d);
		bus(1'b1, HIGH1_REG_ADR, 8'hf0, d);
		bus(1'b1, LOW1_REG_ADR, 8'hfc, d);
		bus(1'b1, TOGGLE_REG_ADR, 8'h02, d);
		`CHK("pin1 level", 1'b1, p1_o)
		bus(1'b1, RUN_REG_ADR, 8'h40, d);
		repeat (56) @(posedge clk_i);
		bus(1'b1, RUN_REG_ADR, 8'h00, d);
		chk_reg(LOW1_REG_ADR, 8'hf6, "reload low1");
		chk_reg(HIGH1_REG_ADR, 8'hf0, "reload high1");
		`CHK("pin1 toggled", 1'b0, p1_o)
		bus(1'b1, TOGGLE_REG_ADR, 8'h00, d);
		// ****
		// counter 0 counts pin edges only with gate high; counter 1 gated off
		// ****
		bus(1'b1, MODE_REG_ADR, 8'h8d, d);
		bus(1'b1, LOW0_REG_ADR, 8'h00, d);
		bus(1'b1, HIGH0_REG_ADR, 8'h00, d);
		bus(1'b1, RUN_REG_ADR, 8'h50, d);
		pulses(4'h3);
		gate <= 2'h1;
		pulses(4'h5);
		chk_reg(LOW0_REG_ADR, 8'h05, "edges");
		chk_reg(HIGH0_REG_ADR, 8'h00, "edges high");
		chk_reg(LOW1_REG_ADR, 8'hf6, "gated low1");
		// ****
		// mode 3 on counter 0, 10 ticks: low byte on run 0, high byte on run 1, counter 1 stopped
		// ****
		bus(1'b1, RUN_REG_ADR, 8'h00, d);
		bus(1'b1, MODE_REG_ADR, 8'h33, d);
		bus(1'b1, LOW0_REG_ADR, 8'hfe, d);
		bus(1'b1, HIGH0_REG_ADR, 8'h00, d);
		bus(1'b0, STATUS_REG_ADR, 8'h00, d);
		// pin one was left low by the reload test, so re-enabling must force it high
		bus(1'b1, TOGGLE_REG_ADR, 8'h03, d);
		`CHK("pin1 re-enabled", 1'b1, p1_o)
		`CHK("pin0 driven", 1'b0, p0_oe_n)
		bus(1'b1, RUN_REG_ADR, 8'h50, d);
		repeat (56) @(posedge clk_i);
		bus(1'b1, RUN_REG_ADR, 8'h00, d);
		`CHK("irq split", 1'b1, irq_o)
		chk_reg(LOW0_REG_ADR, 8'h08, "split low0");
		chk_reg(HIGH0_REG_ADR, 8'h0a, "split high0");
		chk_reg(LOW1_REG_ADR, 8'hf6, "stopped low1");
		chk_reg(STATUS_REG_ADR, 8'h01, "split status");
		`CHK("pin0 toggled", 1'b0, p0_o)
		final_report();
	end
endmodule : dual_timer_counter_tb
